//--- design/dpram_host.sv
// Purpose: drives one port of an asynchronous dual-port ram from a clocked user side
// Assumes: device inputs synchronous to i_mclk; device busy pin is an output (master)
// Notes: one access at a time; each access ends with a recovery gap
// Function
// - strobe high whenever address lines change
// - strobe pulse covers driver turn-off plus setup
// - memory or semaphore select, never both
// - select high flag-update time after semaphore write
// - strobe held low after busy returns high
// - address valid before memory select falls
`timescale 1ns/1ps
module dpram_host
  import dpram_host_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // user request
  input wire dpram_host_pkg::cmd_t i_cmd,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  // user answer
  output logic o_rsp_valid,
  output logic [dpram_host_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_mailbox,
  // device port pins
  output dpram_host_pkg::port_ctl_t o_ctl,
  output logic [dpram_host_pkg::ADDR_W-1:0] o_addr,
  input wire logic [dpram_host_pkg::DATA_W-1:0] i_data,
  output logic [dpram_host_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  input wire logic i_busy_n,
  input wire logic i_int_n
);
  import dpram_host_pkg::*;

  // access sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_END, ST_GAP} state_t;

  state_t state_r, state_nxt; // sequencer state
  logic [3:0] cnt_r, cnt_nxt; // cycles left in the current phase
  op_t op_r, op_nxt; // access kind in flight
  port_ctl_t ctl_r, ctl_nxt; // control pins
  logic [ADDR_W-1:0] addr_r, addr_nxt; // address pins
  logic [DATA_W-1:0] wdata_r, wdata_nxt; // write data pins
  logic doe_n_r, doe_n_nxt; // data pin enable, low drives
  logic [DATA_W-1:0] rdata_r, rdata_nxt; // captured read data
  logic rsp_r, rsp_nxt; // answer pulse
  logic mbox_r, mbox_nxt; // mailbox flag seen at this port
  logic is_write; // access in flight writes
  logic is_sem; // access in flight targets the semaphores

  assign is_write = (op_r == OP_MEM_WRITE) || (op_r == OP_SEM_WRITE);
  assign is_sem = (op_r == OP_SEM_READ) || (op_r == OP_SEM_WRITE);

  // next values of the sequencer and the pins
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    ctl_nxt = ctl_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    doe_n_nxt = doe_n_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    mbox_nxt = ~i_int_n; // mailbox flag is active low at the pin
    unique case (state_r)
      ST_IDLE:
      begin
        // take a request; address moves only while strobe is high
        if (i_cmd_valid)
        begin
          op_nxt = i_cmd.op;
          addr_nxt = i_cmd.addr;
          wdata_nxt = i_cmd.wdata; // bit zero alone counts for semaphores
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // address has stood a full cycle, now assert the select
        ctl_nxt.ce_n = is_sem;
        ctl_nxt.sem_n = ~is_sem;
        ctl_nxt.rw_n = ~is_write;
        ctl_nxt.oe_n = is_write; // output drive high while writing
        doe_n_nxt = ~is_write;
        cnt_nxt = is_write ? WRITE_PULSE_CYC : READ_CYC;
        state_nxt = ST_ACCESS;
      end
      ST_ACCESS:
      begin
        // hold the access; busy low restarts the hold time
        if (!i_busy_n)
          cnt_nxt = is_write ? BUSY_HOLD_CYC : RELEASE_TO_DATA_CYC;
        else if (cnt_r == 4'h1)
        begin
          // end the access by raising select and strobe together
          ctl_nxt = CTL_IDLE;
          doe_n_nxt = 1'b1;
          rdata_nxt = i_data;
          rsp_nxt = 1'b1;
          state_nxt = ST_END;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      ST_END:
      begin
        // address still held here, recovery follows
        cnt_nxt = GAP_CYC;
        state_nxt = ST_GAP;
      end
      ST_GAP:
      begin
        // keep select and output drive high before the next access
        if (cnt_r == 4'h1)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r - 4'h1;
      end
    endcase
  end

  // register the sequencer and all pins
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      op_r <= OP_MEM_READ;
      ctl_r <= CTL_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      doe_n_r <= 1'b1;
      rdata_r <= '0;
      rsp_r <= 1'b0;
      mbox_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      ctl_r <= ctl_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      doe_n_r <= doe_n_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      mbox_r <= mbox_nxt;
    end
  end

  // outputs
  assign o_cmd_ready = (state_r == ST_IDLE);
  assign o_rsp_valid = rsp_r;
  assign o_rsp_data = rdata_r;
  assign o_mailbox = mbox_r;
  assign o_ctl = ctl_r;
  assign o_addr = addr_r;
  assign o_data = wdata_r;
  assign o_data_oe_n = doe_n_r;

  // semaphore write finishing, then select held high
  sequence sem_write_end_s;
    $rose(o_ctl.sem_n) && $past(!o_ctl.rw_n);
  endsequence
  sequence sem_quiet_s;
    o_ctl.sem_n ##1 o_ctl.sem_n;
  endsequence

  chk_addr_strobe_high: assert property (@(posedge i_mclk) disable iff (i_rst)
    $changed(o_addr) |-> o_ctl.rw_n && $past(o_ctl.rw_n))
    else $error("address moved while write strobe low");
  chk_select_exclusive: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(!o_ctl.ce_n && !o_ctl.sem_n))
    else $error("memory and semaphore select both low");
  chk_addr_before_select: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_ctl.ce_n) |-> $stable(o_addr))
    else $error("address changed as memory select fell");
  chk_write_pulse_drive: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_ctl.rw_n) |-> o_ctl.oe_n && !o_data_oe_n)
    else $error("write pulse without output drive high and data driven");
  chk_sem_flag_gap: assert property (@(posedge i_mclk) disable iff (i_rst)
    sem_write_end_s |-> sem_quiet_s)
    else $error("semaphore reselected too soon after write");
  // strobe still low at the edge where busy is first seen high again
  chk_busy_write_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(i_busy_n) && $past(!o_ctl.rw_n) |-> !o_ctl.rw_n)
    else $error("write strobe rose with busy");
  chk_data_drive_oe: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_data_oe_n |-> o_ctl.oe_n && !o_ctl.rw_n)
    else $error("data driven outside a write");
  chk_rsp_after_access: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_rsp_valid |-> o_ctl == CTL_IDLE && $past(!o_ctl.ce_n || !o_ctl.sem_n)
    ##1 !o_rsp_valid)
    else $error("answer not tied to the end of an access");

endmodule

//--- design/dpram_host_pkg.sv
// Purpose: shared types and timing constants for the dual-port ram port controller
// Assumes: one 10 MHz clock; every device timing is shorter than one period
// Notes: nanosecond figures are kept as printed, cycle counts derive from them
package dpram_host_pkg;

  // clock rate, in MHz
  localparam int CLK_MHZ = 10;

  // array geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // device timing figures, in ns
  localparam int MIN_WRITE_PULSE_NS = 20;
  localparam int DRIVER_OFF_NS = 15;
  localparam int DATA_SETUP_NS = 15;
  localparam int BUSY_WRITE_HOLD_NS = 20;
  localparam int FLAG_UPDATE_PULSE_NS = 10;
  localparam int FLAG_WRITE_TO_READ_NS = 5;
  localparam int READ_ACCESS_NS = 25;
  localparam int WRITE_TO_DATA_DELAY_NS = 50;
  localparam int PORT_TO_PORT_DELAY_NS = 30;

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // larger of two figures
  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // write strobe low time, covers driver turn-off plus setup
  localparam logic [3:0] WRITE_PULSE_CYC =
    4'(cyc_up(max2(MIN_WRITE_PULSE_NS, DRIVER_OFF_NS + DATA_SETUP_NS)));
  // strobe hold after busy returns high
  localparam logic [3:0] BUSY_HOLD_CYC = 4'(cyc_up(BUSY_WRITE_HOLD_NS));
  // read access time with select and output drive low
  localparam logic [3:0] READ_CYC = 4'(cyc_up(READ_ACCESS_NS));
  // read data settle after busy release
  localparam logic [3:0] RELEASE_TO_DATA_CYC = 4'(cyc_up(max2(
    WRITE_TO_DATA_DELAY_NS - MIN_WRITE_PULSE_NS, PORT_TO_PORT_DELAY_NS - DATA_SETUP_NS)));
  // recovery between accesses, covers the semaphore flag update pulse
  localparam logic [3:0] GAP_CYC =
    4'(cyc_up(max2(FLAG_UPDATE_PULSE_NS, FLAG_WRITE_TO_READ_NS)));

  // idle level of the port control pins
  localparam logic [3:0] CTL_IDLE = 4'hF;

  // access kinds
  typedef enum logic [1:0] {OP_MEM_READ, OP_MEM_WRITE, OP_SEM_READ, OP_SEM_WRITE} op_t;

  // request from the user side
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmd_t;

  // port control pins, all active low
  typedef struct packed {
    logic ce_n;
    logic sem_n;
    logic rw_n;
    logic oe_n;
  } port_ctl_t;

endpackage

//--- bench/dpram_port_model.sv
// Purpose: behavioural device port facing the host block
// Assumes: host pins change just after i_mclk edges
// Notes: the peer port is reduced to ownership and mail inputs
`timescale 1ns/1ps
module dpram_port_model
  import dpram_host_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // host pins
  input wire dpram_host_pkg::port_ctl_t i_ctl,
  input wire logic [dpram_host_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dpram_host_pkg::DATA_W-1:0] i_wd,
  output logic [dpram_host_pkg::DATA_W-1:0] o_rd,
  output logic o_int_n,
  // peer side
  input wire logic [7:0] i_peer_own,
  input wire logic i_peer_mail
);
  logic [7:0] mem [0:4095]; // array of 4K bytes
  logic [7:0] want_r = 8'h00; // our requests, one per latch
  logic [7:0] last_r = 8'h00; // last level seen on the pins
  logic sem_v;
  wire wr = !i_ctl.rw_n && !(i_ctl.ce_n && i_ctl.sem_n);
  wire rd = i_ctl.rw_n && !i_ctl.oe_n && (i_ctl.ce_n != i_ctl.sem_n);
  // pending request wins once the peer lets go
  assign sem_v = !(want_r[i_addr[2:0]] && !i_peer_own[i_addr[2:0]]);
  // released pins show the inverse of the last level
  assign o_rd = !rd ? ~last_r : !i_ctl.ce_n ? mem[i_addr] : {8{sem_v}};
  initial o_int_n = 1'b1;
  // commit writes, keep the mail flag
  always @(posedge i_mclk)
  begin
    // remember only what was really driven, so released pins hold steady
    if (rd) last_r <= o_rd;
    if (wr && !i_ctl.ce_n) mem[i_addr] <= i_wd;
    if (wr && !i_ctl.sem_n) want_r[i_addr[2:0]] <= !i_wd[0];
    if (i_peer_mail) o_int_n <= 1'b0;
    else if (rd && !i_ctl.ce_n && i_addr == 12'hFFE) o_int_n <= 1'b1;
  end
endmodule

//--- bench/dual_port_ram_arbiter_tb.sv
// Purpose: self-checking bench for the port controller
// Assumes: device model stands in for the ram port
// Notes: busy is driven by the bench to play contention
`timescale 1ns/1ps
module dual_port_ram_arbiter_tb;
  import dpram_host_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  cmd_t i_cmd = '0;
  logic i_cmd_valid = 1'b0;
  logic i_busy_n = 1'b1;
  logic [7:0] peer_own = 8'h00; // latches held by the peer
  logic peer_mail = 1'b0; // peer writes the mail word
  logic o_cmd_ready, o_rsp_valid, o_mailbox, o_data_oe_n, int_n, rw_q;
  logic [7:0] o_rsp_data, o_data, dev_rd, bus;
  logic [11:0] o_addr, addr_q;
  port_ctl_t o_ctl;
  int err_total = 0;
  int samples_checked = 0;
  assign bus = !o_data_oe_n ? o_data : dev_rd; // shared data wire
  always #50 i_mclk = ~i_mclk;
  dpram_host u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd(i_cmd),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_mailbox(o_mailbox), .o_ctl(o_ctl), .o_addr(o_addr),
    .i_data(bus), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .i_busy_n(i_busy_n),
    .i_int_n(int_n));
  dpram_port_model u_dev (.i_mclk(i_mclk), .i_ctl(o_ctl), .i_addr(o_addr), .i_wd(bus),
    .o_rd(dev_rd), .o_int_n(int_n), .i_peer_own(peer_own), .i_peer_mail(peer_mail));
  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  // one access; busy held low for nb cycles after the take
  task automatic access(input op_t op, input logic [11:0] a, input logic [7:0] d,
    input int nb);
    int k;
    logic wr_op;
    wr_op = (op == OP_MEM_WRITE) || (op == OP_SEM_WRITE);
    for (k = 0; k < 20 && o_cmd_ready !== 1'b1; k++)
    begin
      @(posedge i_mclk);
      #1;
    end
    // ready never came back, count it and close the run
    if (o_cmd_ready !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
    @(posedge i_mclk);
    i_cmd <= '{op, a, d};
    i_cmd_valid <= 1'b1;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    i_busy_n <= (nb > 0) ? 1'b0 : 1'b1;
    for (k = 1; k < 20; k++)
    begin
      @(posedge i_mclk);
      i_busy_n <= (k < nb) ? 1'b0 : 1'b1;
      #1;
      if (o_rsp_valid === 1'b1)
        break;
    end
    if (k == 20)
    begin
      err_total++;
      tally_and_finish();
    end
    // setup cycle plus the strobe or read hold, or busy cycles plus the release hold
    if (nb == 0)
      cmp_byte(8'(k), 8'(1 + (wr_op ? WRITE_PULSE_CYC : READ_CYC)));
    else
      cmp_byte(8'(k), 8'(nb + (wr_op ? BUSY_HOLD_CYC : RELEASE_TO_DATA_CYC)));
  endtask
  // address pins move only with strobe high, selects never both low
  always @(posedge i_mclk)
  begin
    #1;
    if (!i_rst && o_addr !== addr_q)
      cmp_bit(rw_q & o_ctl.rw_n, 1'b1);
    if (!i_rst)
      cmp_bit(o_ctl.ce_n | o_ctl.sem_n, 1'b1);
    addr_q = o_addr;
    rw_q = o_ctl.rw_n;
  end
  // back-to-back writes at both ends of the array
  task automatic run_mem();
    access(OP_MEM_WRITE, 12'h000, 8'h5A, 0);
    access(OP_MEM_WRITE, 12'hFFF, 8'hA5, 0);
    access(OP_MEM_READ, 12'h000, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'h5A);
    access(OP_MEM_READ, 12'hFFF, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'hA5);
  endtask
  // request, refusal while peer owns, grant on release
  task automatic run_sem();
    peer_own <= 8'h20;
    access(OP_SEM_WRITE, 12'h003, 8'hFE, 0);
    access(OP_SEM_READ, 12'hFFB, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'h00);
    access(OP_SEM_WRITE, 12'h005, 8'h00, 0);
    access(OP_SEM_READ, 12'h00D, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'hFF);
    peer_own <= 8'h00;
    access(OP_SEM_READ, 12'h005, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'h00);
    access(OP_SEM_WRITE, 12'h003, 8'h01, 0);
    access(OP_SEM_READ, 12'h003, 8'h00, 0);
    cmp_byte(o_rsp_data, 8'hFF);
  endtask
  // write and read held off by busy
  task automatic run_busy();
    access(OP_MEM_WRITE, 12'h123, 8'h3C, 4);
    access(OP_MEM_READ, 12'h123, 8'h00, 3);
    cmp_byte(o_rsp_data, 8'h3C);
  endtask
  // mail flag set by the peer, cleared by our read
  task automatic run_mail();
    @(posedge i_mclk);
    peer_mail <= 1'b1;
    @(posedge i_mclk);
    peer_mail <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    cmp_bit(o_mailbox, 1'b1);
    access(OP_MEM_READ, 12'hFFE, 8'h00, 0);
    repeat (2) @(posedge i_mclk);
    #1;
    cmp_bit(o_mailbox, 1'b0);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    cmp_byte({o_ctl, o_data_oe_n, o_rsp_valid, o_mailbox, o_cmd_ready}, 8'hF9);
    run_mem();
    run_sem();
    run_busy();
    run_mail();
    tally_and_finish();
  end
endmodule
